// ### pkg/lpe_pkg.sv
// Shared constants for the low-power entry controller and its driver
package lpe_pkg;
    // Result codes
    localparam logic [3:0] RESULT_OK = 4'h0;
    localparam logic [3:0] ERR_OSC_STOP = 4'h1;
    localparam logic [3:0] ERR_CLOCK_OVER_LIMIT = 4'h2;
    localparam logic [3:0] ERR_MAIN_CLOCK_TOO_FAST = 4'h3;
    localparam logic [3:0] ERR_BAD_RETURN_CLOCK = 4'h4;
    localparam logic [3:0] ERR_FLASH_BUSY = 4'h5;
    localparam logic [3:0] ERR_DEEP_SLEEP_COND = 4'h6;
    localparam logic [3:0] ERR_BAD_PARAM = 4'h7;
    localparam logic [3:0] ERR_ILLEGAL = 4'h8;
    // Low-power modes
    localparam logic [2:0] MODE_SLEEP = 3'h0;
    localparam logic [2:0] MODE_DEEP_SLEEP = 3'h1;
    localparam logic [2:0] MODE_ALL_STOP = 3'h2;
    localparam logic [2:0] MODE_SW_STANDBY = 3'h3;
    localparam logic [2:0] MODE_DEEP_SW_STANDBY = 3'h4;
    // Operating power levels, larger code is slower
    localparam logic [2:0] LVL_HIGH = 3'h0;
    localparam logic [2:0] POWER_LEVEL_MIDDLE = 3'h2;
    localparam logic [2:0] LVL_MIDDLE_2 = 3'h4;
    localparam logic [2:0] LVL_LOW = 3'h6;
    localparam logic [2:0] LVL_LOW_2 = 3'h7;
    // Sleep return clocks
    localparam logic [1:0] RCLK_SLOW_OSC = 2'h0;
    localparam logic [1:0] RCLK_FAST_ONCHIP_OSC = 2'h1;
    localparam logic [1:0] RCLK_MAIN = 2'h2;
    // System clock sources
    localparam logic [2:0] SCLK_SLOW_OSC = 3'h0;
    localparam logic [2:0] SCLK_FAST_ONCHIP_OSC = 3'h1;
    localparam logic [2:0] SCLK_MAIN = 3'h2;
    localparam logic [2:0] SCLK_SUB = 3'h3;
    localparam logic [2:0] SCLK_PLL = 3'h4;
    // Reset values
    localparam logic [2:0] RST_LEVEL = LVL_HIGH;
    localparam logic [2:0] RST_MODE = MODE_SLEEP;
    localparam logic [3:0] RST_CLK_CLASS = 4'h0;
    localparam int WAKE_SRC_W = 3;
    // Driver register map
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_CLOCK = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Control word fields
    localparam int CT_OP_LSB = 0;
    localparam int CT_ARG_LSB = 4;
    localparam int CT_HOOK_BIT = 7;
    localparam int CT_WAKE_LSB = 8;
    localparam int CT_CLK_LSB = 12;
    localparam logic [1:0] OP_SELECT = 2'h1;
    localparam logic [1:0] OP_PERF = 2'h2;
    localparam logic [1:0] OP_ENTER = 2'h3;
    // Status word fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_CODE_LSB = 4;
    localparam int ST_LP_BIT = 8;
    localparam int ST_IRQ_BIT = 9;
    localparam int ST_LVL_LSB = 12;
endpackage

// ### pkg/lpe_link_if.sv
// Link between the halting core driver and the low-power controller
`timescale 1ns/1ns
interface lpe_link_if;
    logic sel_vld;
    logic [2:0] sel_mode;
    logic lvl_vld;
    logic [2:0] lvl;
    logic int_off;
    logic wake_vld;
    logic [2:0] wake_src;
    logic halt;
    logic rsp_vld;
    logic [3:0] rsp_code;
    logic wr_ack;
    logic lp_active;
    logic irq_en;
    logic [2:0] cur_lvl;
    modport dev (
        input sel_vld, sel_mode, lvl_vld, lvl, int_off, wake_vld,
        input wake_src, halt,
        output rsp_vld, rsp_code, wr_ack, lp_active, irq_en, cur_lvl
    );
    modport ctl (
        output sel_vld, sel_mode, lvl_vld, lvl, int_off, wake_vld,
        output wake_src, halt,
        input rsp_vld, rsp_code, wr_ack, lp_active, irq_en, cur_lvl
    );
endinterface

// ### core/lpe_dev.sv
// Low-power entry and power-level controller
`timescale 1ns/1ns
//
// Contract
// - Raise power level before raising clocks
// - Lower clocks before lowering power level
// - Selected mode applies only on halt
// - Selecting a mode only stores it
// - In low power the core is halted
// - Disable irqs, set wake, confirm write, halt
// - Accepted halt re-enables interrupts internally
// - Optional hook sets wake source, null skips
// - Small part sleep switching needs sub-clock
// - Large part switching needs main or sub
// - Middle return forbids fast oscillator return
// - Middle return on main needs middle clocks
// - Large part fast oscillator return needs power
// - All-stop needs module stop conditions met
// - All-stop refused during flash program/erase
// - Deep sleep needs transfer controllers stopped
// - Deep sleep refused during flash program/erase
// - Standby refused with oscillation-stop detect
// - Other failures illegal, success reports ok
// - Level change refused if clocks too fast
// - Level change refused during flash activity
// - Small part low level needs sub-clock
module lpe_dev #(
    parameter bit LARGE = 1'b0,
    parameter int WAKE_W = 8
) (
    input logic aclk,
    input logic aresetn,
    lpe_link_if.dev link,
    input logic rc_sw_en,
    input logic [2:0] sys_clk,
    input logic [1:0] ret_clk,
    input logic ret_mid,
    input logic clk_over_mid,
    input logic [2:0] clk_min_level,
    input logic fast_onchip_oscillator_on,
    input logic module_stop_ctrl_a_ok,
    input logic transfer_ctrl_stop_bit,
    input logic flash_pe,
    input logic osc_det_en,
    input logic [WAKE_W-1:0] wake_evt,
    output logic core_halt,
    output logic [2:0] lp_mode,
    output logic [2:0] op_level
);
    typedef enum logic {
        S_RUN,
        S_LOW
    } lpe_dev_st_t;

    generate
        if (WAKE_W < 1 || WAKE_W > (1 << lpe_pkg::WAKE_SRC_W))
        begin : g_bad_w
            $error("WAKE_W out of range");
        end
    endgenerate

    lpe_dev_st_t st_r;
    logic [2:0] mode_r;
    logic [2:0] lvl_r;
    logic [2:0] wake_src_r;
    logic irq_en_r;
    logic rsp_vld_r;
    logic [3:0] rsp_code_r;
    logic wr_ack_r;
    logic core_halt_r;
    logic [2:0] lp_mode_r;
    logic [WAKE_W-1:0] wk_s1_r;
    logic [WAKE_W-1:0] wk_s2_r;
    logic [3:0] ent_code;
    logic [3:0] lvl_code;
    logic wake_hit;

    function automatic logic lvl_valid(input logic [2:0] l);
        if (LARGE)
        begin
            lvl_valid = (l == lpe_pkg::LVL_HIGH) ||
                        (l == lpe_pkg::LVL_LOW) ||
                        (l == lpe_pkg::LVL_LOW_2);
        end
        else
        begin
            lvl_valid = (l == lpe_pkg::LVL_HIGH) ||
                        (l == lpe_pkg::POWER_LEVEL_MIDDLE) ||
                        (l == lpe_pkg::LVL_MIDDLE_2) ||
                        (l == lpe_pkg::LVL_LOW);
        end
    endfunction

    // Wake events arrive from pins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wk_s1_r <= '0;
            wk_s2_r <= '0;
        end
        else
        begin
            wk_s1_r <= wake_evt;
            wk_s2_r <= wk_s1_r;
        end
    end

    always_comb
    begin
        wake_hit = 1'b0;
        for (int i = 0; i < WAKE_W; i++)
        begin
            if (wk_s2_r[i] && wake_src_r == 3'(i))
            begin
                wake_hit = 1'b1;
            end
        end
    end

    // Entry preconditions, first failure wins
    always_comb
    begin
        ent_code = lpe_pkg::RESULT_OK;
        case (mode_r)
            lpe_pkg::MODE_SLEEP:
            begin
                if (rc_sw_en && !LARGE)
                begin
                    if (sys_clk != lpe_pkg::SCLK_SUB)
                        ent_code = lpe_pkg::ERR_BAD_RETURN_CLOCK;
                    else if (ret_mid &&
                             ret_clk == lpe_pkg::RCLK_FAST_ONCHIP_OSC)
                        ent_code = lpe_pkg::ERR_BAD_RETURN_CLOCK;
                    else if (ret_mid && ret_clk == lpe_pkg::RCLK_MAIN &&
                             clk_over_mid)
                        ent_code = lpe_pkg::ERR_MAIN_CLOCK_TOO_FAST;
                end
                else if (rc_sw_en)
                begin
                    if (sys_clk != lpe_pkg::SCLK_MAIN &&
                        sys_clk != lpe_pkg::SCLK_SUB)
                        ent_code = lpe_pkg::ERR_BAD_RETURN_CLOCK;
                    else if (ret_clk == lpe_pkg::RCLK_FAST_ONCHIP_OSC &&
                             !fast_onchip_oscillator_on)
                        ent_code = lpe_pkg::ERR_BAD_RETURN_CLOCK;
                end
            end
            lpe_pkg::MODE_DEEP_SLEEP:
            begin
                if (LARGE)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
                else if (!transfer_ctrl_stop_bit)
                    ent_code = lpe_pkg::ERR_DEEP_SLEEP_COND;
                else if (flash_pe)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
            end
            lpe_pkg::MODE_ALL_STOP:
            begin
                if (!LARGE)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
                else if (!module_stop_ctrl_a_ok)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
                else if (flash_pe)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
            end
            lpe_pkg::MODE_SW_STANDBY:
            begin
                if (osc_det_en)
                    ent_code = lpe_pkg::ERR_OSC_STOP;
                else if (flash_pe)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
            end
            lpe_pkg::MODE_DEEP_SW_STANDBY:
            begin
                if (!LARGE)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
                else if (osc_det_en)
                    ent_code = lpe_pkg::ERR_OSC_STOP;
                else if (flash_pe)
                    ent_code = lpe_pkg::ERR_ILLEGAL;
            end
            default:
            begin
                ent_code = lpe_pkg::ERR_ILLEGAL;
            end
        endcase
    end

    // Power-level change checks
    always_comb
    begin
        lvl_code = lpe_pkg::RESULT_OK;
        if (flash_pe)
            lvl_code = lpe_pkg::ERR_FLASH_BUSY;
        else if (!lvl_valid(link.lvl))
            lvl_code = lpe_pkg::ERR_BAD_PARAM;
        else if (link.lvl > clk_min_level)
            lvl_code = lpe_pkg::ERR_CLOCK_OVER_LIMIT;
        else if (!LARGE && link.lvl == lpe_pkg::LVL_LOW &&
                 sys_clk != lpe_pkg::SCLK_SUB)
            lvl_code = lpe_pkg::ERR_CLOCK_OVER_LIMIT;
    end

    // Request handling and low-power state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= S_RUN;
            mode_r <= lpe_pkg::RST_MODE;
            lvl_r <= lpe_pkg::RST_LEVEL;
            irq_en_r <= 1'b1;
            rsp_vld_r <= 1'b0;
            rsp_code_r <= lpe_pkg::RESULT_OK;
            core_halt_r <= 1'b0;
            lp_mode_r <= lpe_pkg::RST_MODE;
        end
        else
        begin
            rsp_vld_r <= 1'b0;
            if (link.int_off)
                irq_en_r <= 1'b0;
            case (st_r)
                S_RUN:
                begin
                    if (link.halt)
                    begin
                        rsp_vld_r <= 1'b1;
                        rsp_code_r <= ent_code;
                        if (ent_code == lpe_pkg::RESULT_OK)
                        begin
                            st_r <= S_LOW;
                            core_halt_r <= 1'b1;
                            lp_mode_r <= mode_r;
                            irq_en_r <= 1'b1;
                        end
                    end
                    else if (link.lvl_vld)
                    begin
                        rsp_vld_r <= 1'b1;
                        rsp_code_r <= lvl_code;
                        if (lvl_code == lpe_pkg::RESULT_OK)
                            lvl_r <= link.lvl;
                    end
                    else if (link.sel_vld)
                    begin
                        mode_r <= link.sel_mode;
                        rsp_vld_r <= 1'b1;
                        rsp_code_r <= lpe_pkg::RESULT_OK;
                    end
                end
                S_LOW:
                begin
                    if (irq_en_r && wake_hit)
                    begin
                        st_r <= S_RUN;
                        core_halt_r <= 1'b0;
                    end
                end
                default:
                begin
                    st_r <= S_RUN;
                end
            endcase
        end
    end

    // Wake source setup and write confirmation
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wake_src_r <= '0;
            wr_ack_r <= 1'b0;
        end
        else
        begin
            wr_ack_r <= link.wake_vld;
            if (link.wake_vld)
                wake_src_r <= link.wake_src;
        end
    end

    assign link.rsp_vld = rsp_vld_r;
    assign link.rsp_code = rsp_code_r;
    assign link.wr_ack = wr_ack_r;
    assign link.lp_active = core_halt_r;
    assign link.irq_en = irq_en_r;
    assign link.cur_lvl = lvl_r;
    assign core_halt = core_halt_r;
    assign lp_mode = lp_mode_r;
    assign op_level = lvl_r;
endmodule

// ### core/lpe_ctl.sv
// Driver end: AXI4-Lite commands sequenced onto the controller link
`timescale 1ns/1ns
module lpe_ctl (
    input logic aclk,
    input logic aresetn,
    input logic [3:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [3:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    lpe_link_if.ctl link,
    output logic [3:0] clk_class
);
    typedef enum logic [3:0] {
        H_IDLE, H_SEL, H_LVL, H_LWAIT, H_CLK,
        H_DIS, H_HOOK, H_WACK, H_HALT, H_WAIT
    } lpe_ctl_st_t;

    lpe_ctl_st_t st_r;
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [3:0] aw_addr_r;
    logic [31:0] wdata_r, rdata_r, rd_word;
    logic [3:0] wstrb_r;
    logic [15:0] cmd_r;
    logic [3:0] code_r, clk_class_r;
    logic raise_r;
    logic sel_vld_r, lvl_vld_r, int_off_r, wake_vld_r, halt_r;
    logic wr_fire, start;

    assign wr_fire = !awready_r && !wready_r && !bvalid_r;
    assign start = wr_fire && aw_addr_r == lpe_pkg::OFF_CTRL &&
                   wstrb_r[1:0] == 2'b11 && st_r == H_IDLE;

    always_comb
    begin
        rd_word = 32'h0;
        case (araddr)
            lpe_pkg::OFF_CTRL: rd_word[15:0] = cmd_r;
            lpe_pkg::OFF_STATUS:
            begin
                rd_word[lpe_pkg::ST_BUSY_BIT] = (st_r != H_IDLE);
                rd_word[lpe_pkg::ST_CODE_LSB +: 4] = code_r;
                rd_word[lpe_pkg::ST_LP_BIT] = link.lp_active;
                rd_word[lpe_pkg::ST_IRQ_BIT] = link.irq_en;
                rd_word[lpe_pkg::ST_LVL_LSB +: 3] = link.cur_lvl;
            end
            lpe_pkg::OFF_CLOCK: rd_word[3:0] = clk_class_r;
            default: rd_word = 32'h0;
        endcase
    end

    // AXI4-Lite slave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= lpe_pkg::RESP_OKAY;
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rresp_r <= lpe_pkg::RESP_OKAY;
            rdata_r <= 32'h0;
            aw_addr_r <= 4'h0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end
        else
        begin
            if (awvalid && awready_r)
            begin
                aw_addr_r <= awaddr;
                awready_r <= 1'b0;
            end
            if (wvalid && wready_r)
            begin
                wdata_r <= wdata;
                wstrb_r <= wstrb;
                wready_r <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_r <= 1'b1;
                bresp_r <= (aw_addr_r == lpe_pkg::OFF_CTRL) ?
                           lpe_pkg::RESP_OKAY : lpe_pkg::RESP_SLVERR;
            end
            if (bvalid_r && bready)
            begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
            if (arvalid && arready_r)
            begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= (araddr == lpe_pkg::OFF_CTRL ||
                            araddr == lpe_pkg::OFF_STATUS ||
                            araddr == lpe_pkg::OFF_CLOCK) ?
                           lpe_pkg::RESP_OKAY : lpe_pkg::RESP_SLVERR;
            end
            if (rvalid_r && rready)
            begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // Command sequencer
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_r <= H_IDLE;
            cmd_r <= 16'h0;
            code_r <= lpe_pkg::RESULT_OK;
            clk_class_r <= lpe_pkg::RST_CLK_CLASS;
            raise_r <= 1'b0;
            sel_vld_r <= 1'b0;
            lvl_vld_r <= 1'b0;
            int_off_r <= 1'b0;
            wake_vld_r <= 1'b0;
            halt_r <= 1'b0;
        end
        else
        begin
            sel_vld_r <= 1'b0;
            lvl_vld_r <= 1'b0;
            int_off_r <= 1'b0;
            wake_vld_r <= 1'b0;
            halt_r <= 1'b0;
            case (st_r)
                H_IDLE:
                begin
                    if (start)
                    begin
                        cmd_r <= wdata_r[15:0];
                        case (wdata_r[lpe_pkg::CT_OP_LSB +: 2])
                            lpe_pkg::OP_SELECT: st_r <= H_SEL;
                            lpe_pkg::OP_PERF:
                            begin
                                raise_r <= wdata_r[lpe_pkg::CT_ARG_LSB +: 3]
                                           < link.cur_lvl;
                                st_r <= (wdata_r[lpe_pkg::CT_ARG_LSB +: 3]
                                        < link.cur_lvl) ? H_LVL : H_CLK;
                            end
                            lpe_pkg::OP_ENTER: st_r <= H_DIS;
                            default: st_r <= H_IDLE;
                        endcase
                    end
                end
                H_SEL:
                begin
                    sel_vld_r <= 1'b1;
                    st_r <= H_WAIT;
                end
                H_LVL:
                begin
                    lvl_vld_r <= 1'b1;
                    st_r <= H_LWAIT;
                end
                H_LWAIT:
                begin
                    if (link.rsp_vld)
                    begin
                        code_r <= link.rsp_code;
                        st_r <= (raise_r &&
                                 link.rsp_code == lpe_pkg::RESULT_OK) ?
                                H_CLK : H_IDLE;
                    end
                end
                H_CLK:
                begin
                    clk_class_r <= cmd_r[lpe_pkg::CT_CLK_LSB +: 4];
                    st_r <= raise_r ? H_IDLE : H_LVL;
                end
                H_DIS:
                begin
                    int_off_r <= 1'b1;
                    st_r <= H_HOOK;
                end
                H_HOOK:
                begin
                    if (cmd_r[lpe_pkg::CT_HOOK_BIT])
                    begin
                        wake_vld_r <= 1'b1;
                        st_r <= H_WACK;
                    end
                    else
                        st_r <= H_HALT;
                end
                H_WACK:
                begin
                    if (link.wr_ack)
                        st_r <= H_HALT;
                end
                H_HALT:
                begin
                    halt_r <= 1'b1;
                    st_r <= H_WAIT;
                end
                H_WAIT:
                begin
                    if (link.rsp_vld)
                    begin
                        code_r <= link.rsp_code;
                        st_r <= H_IDLE;
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rresp = rresp_r;
    assign rdata = rdata_r;
    assign clk_class = clk_class_r;
    assign link.sel_vld = sel_vld_r;
    assign link.sel_mode = cmd_r[lpe_pkg::CT_ARG_LSB +: 3];
    assign link.lvl_vld = lvl_vld_r;
    assign link.lvl = cmd_r[lpe_pkg::CT_ARG_LSB +: 3];
    assign link.int_off = int_off_r;
    assign link.wake_vld = wake_vld_r;
    assign link.wake_src = cmd_r[lpe_pkg::CT_WAKE_LSB +: 3];
    assign link.halt = halt_r;
endmodule

// ### sim/lpe_asserts.sv
// Concurrent checks on the controller link
`timescale 1ns/1ns
module lpe_asserts (
    input logic aclk,
    input logic aresetn,
    input logic sel_vld,
    input logic lvl_vld,
    input logic [2:0] lvl,
    input logic int_off,
    input logic wake_vld,
    input logic halt,
    input logic rsp_vld,
    input logic [3:0] rsp_code,
    input logic wr_ack,
    input logic lp_active,
    input logic irq_en,
    input logic [2:0] cur_lvl
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire ok = rsp_code == lpe_pkg::RESULT_OK;
    sequence s_halt;
        halt && !lp_active;
    endsequence
    sequence s_lvl;
        lvl_vld && !lp_active && !halt;
    endsequence
    AST_RSP: assert property ((sel_vld || lvl_vld || halt) && !lp_active |=> rsp_vld)
        else $error("request not answered");
    AST_WACK: assert property (wake_vld |=> wr_ack)
        else $error("wake write not acknowledged");
    AST_IOFF: assert property (int_off && !halt |=> !irq_en)
        else $error("interrupts not disabled");
    AST_HALT_OK: assert property (s_halt ##1 rsp_vld && ok |-> lp_active && irq_en)
        else $error("accepted halt did not enter low power");
    AST_HALT_REJ: assert property (s_halt ##1 rsp_vld && !ok
        |-> !lp_active && $stable(irq_en) && $stable(cur_lvl))
        else $error("rejected halt changed state");
    AST_SEL: assert property (sel_vld && !halt && !lvl_vld |=> !lp_active)
        else $error("selection entered low power");
    AST_ENTRY: assert property ($rose(lp_active) |-> $past(halt))
        else $error("low power entered without halt");
    AST_LVL_REJ: assert property (s_lvl ##1 rsp_vld && !ok |-> $stable(cur_lvl))
        else $error("rejected level change applied");
    AST_LVL_OK: assert property (s_lvl ##1 rsp_vld && ok |-> cur_lvl == $past(lvl))
        else $error("accepted level not applied");
endmodule

// ### sim/testbench.sv
// Self-checking bench for the low-power entry controller pair
`timescale 1ns/1ns
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, clk_class;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, rnd = 32'h982D, s;
    logic awready, wready, bvalid, arready, rvalid, core_halt;
    logic [1:0] bresp, rresp, r;
    logic [13:0] cfg = 14'h0;
    logic [7:0] wake_evt = 8'h0;
    logic [2:0] lp_mode, op_level, widx = 3'h0;
    logic [3:0] q[$];
    int n_mismatch = 0, total_checks = 0;
    lpe_link_if link ();
    always #20 aclk = ~aclk;
    lpe_ctl lpe_ctl_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
        .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready(1'b1), .link(link.ctl), .clk_class);
    lpe_dev lpe_dev_i (.aclk, .aresetn, .link(link.dev),
        .rc_sw_en(cfg[0]), .sys_clk(cfg[3:1]), .ret_clk(cfg[5:4]),
        .ret_mid(cfg[6]), .clk_over_mid(cfg[7]), .clk_min_level(cfg[10:8]),
        .fast_onchip_oscillator_on(1'b1), .module_stop_ctrl_a_ok(1'b1),
        .transfer_ctrl_stop_bit(cfg[11]), .flash_pe(cfg[12]),
        .osc_det_en(cfg[13]), .wake_evt, .core_halt, .lp_mode, .op_level);
    lpe_asserts lpe_asserts_i (.aclk, .aresetn, .sel_vld(link.sel_vld),
        .lvl_vld(link.lvl_vld), .lvl(link.lvl), .int_off(link.int_off),
        .wake_vld(link.wake_vld), .halt(link.halt), .rsp_vld(link.rsp_vld),
        .rsp_code(link.rsp_code), .wr_ack(link.wr_ack),
        .lp_active(link.lp_active), .irq_en(link.irq_en),
        .cur_lvl(link.cur_lvl));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [31:0] v, input logic [31:0] e);
        total_checks++;
        if (v !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h, want %h", $time, v, e);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        s = rdata;
        r = rresp;
    endtask
    task automatic sc(logic [13:0] c, logic [1:0] op, logic [2:0] a,
        logic [3:0] e);
        logic [31:0] d;
        logic [2:0] ol;
        cfg <= c;
        rnd = xs(rnd);
        d = {16'h0, rnd[15:12], 1'b0, rnd[10:8], rnd[7], a, 2'h0, op};
        // Wake hook forced on for a good entry so the exit source is known
        d[7] = d[7] | (op == lpe_pkg::OP_ENTER && e == lpe_pkg::RESULT_OK);
        if (d[7]) widx = d[10:8];
        ol = op_level;
        q.push_back(e);
        wr(lpe_pkg::OFF_CTRL, d);
        chk(r, lpe_pkg::RESP_OKAY);
        do
            rd(lpe_pkg::OFF_STATUS);
        while (s[0] !== 1'b0);
        chk(s[7:4], e);
        if (e !== lpe_pkg::RESULT_OK) chk(op_level, ol);
        if (op == lpe_pkg::OP_SELECT) chk(core_halt, 1'b0);
        if (op == lpe_pkg::OP_PERF && e == lpe_pkg::RESULT_OK)
        begin
            chk(op_level, a);
            chk(clk_class, d[15:12]);
        end
        if (op == lpe_pkg::OP_ENTER && e == lpe_pkg::RESULT_OK)
        begin
            chk({core_halt, link.lp_active, link.irq_en}, 3'h7);
            wake_evt <= 8'h1 << widx;
            repeat (8) @(posedge aclk);
            chk({core_halt, link.lp_active}, 2'h0);
            wake_evt <= 8'h0;
        end
        $display("Test op %0d arg %0d done", op, a);
    endtask
    task automatic en(logic [13:0] c, logic [2:0] m, logic [3:0] e);
        sc(c, lpe_pkg::OP_SELECT, m, lpe_pkg::RESULT_OK);
        sc(c, lpe_pkg::OP_ENTER, 3'h0, e);
        if (e == lpe_pkg::RESULT_OK) chk(lp_mode, m);
    endtask
    always @(posedge aclk)
        if (link.rsp_vld === 1'b1)
            chk(link.rsp_code, q.size() ? q.pop_front() : 4'hF);
    initial
    begin
        #400000;
        n_mismatch++;
        wrap_up;
    end
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({link.irq_en, link.cur_lvl, clk_class}, 8'h80);
        rd(4'hC);
        chk({r, s[29:0]}, {lpe_pkg::RESP_SLVERR, 30'h0});
        wr(lpe_pkg::OFF_STATUS, 32'h0);
        chk(r, lpe_pkg::RESP_SLVERR);
        en(14'h0007, lpe_pkg::MODE_SLEEP, lpe_pkg::RESULT_OK);
        en(14'h0005, lpe_pkg::MODE_SLEEP, lpe_pkg::ERR_BAD_RETURN_CLOCK);
        en(14'h0057, lpe_pkg::MODE_SLEEP, lpe_pkg::ERR_BAD_RETURN_CLOCK);
        en(14'h00E7, lpe_pkg::MODE_SLEEP, lpe_pkg::ERR_MAIN_CLOCK_TOO_FAST);
        en(14'h0000, lpe_pkg::MODE_DEEP_SLEEP, lpe_pkg::ERR_DEEP_SLEEP_COND);
        en(14'h1800, lpe_pkg::MODE_DEEP_SLEEP, lpe_pkg::ERR_ILLEGAL);
        en(14'h2800, lpe_pkg::MODE_SW_STANDBY, lpe_pkg::ERR_OSC_STOP);
        en(14'h0800, lpe_pkg::MODE_ALL_STOP, lpe_pkg::ERR_ILLEGAL);
        en(14'h0000, lpe_pkg::MODE_SW_STANDBY, lpe_pkg::RESULT_OK);
        sc(14'h1606, 2'h2, lpe_pkg::LVL_LOW, lpe_pkg::ERR_FLASH_BUSY);
        sc(14'h0006, 2'h2, lpe_pkg::LVL_LOW, lpe_pkg::ERR_CLOCK_OVER_LIMIT);
        sc(14'h0606, 2'h2, lpe_pkg::POWER_LEVEL_MIDDLE, lpe_pkg::RESULT_OK);
        sc(14'h0606, 2'h2, 3'h1, lpe_pkg::ERR_BAD_PARAM);
        sc(14'h0602, 2'h2, lpe_pkg::LVL_LOW, lpe_pkg::ERR_CLOCK_OVER_LIMIT);
        sc(14'h0606, 2'h2, lpe_pkg::LVL_HIGH, lpe_pkg::RESULT_OK);
        wrap_up;
    end
endmodule
